//--- afl_cfg.svh
// Constants for the absolute field load unit: offsets, field positions, opcode, timing.
`ifndef AFL_CFG_SVH
`define AFL_CFG_SVH

// Register offsets on the plain register port
`define AFL_OFS_CFG       8'h00
`define AFL_OFS_STATUS    8'h04
`define AFL_OFS_RF_BASE   8'h80
`define AFL_OFS_RF_MASK   8'h80

// Field configuration register layout
`define AFL_CFG_W0_LSB    0
`define AFL_CFG_E0_BIT    5
`define AFL_CFG_W1_LSB    8
`define AFL_CFG_E1_BIT    13
`define AFL_CFG_RESET     32'h0000_0000

// Status register layout
`define AFL_ST_V          0
`define AFL_ST_Z          1
`define AFL_ST_C          2
`define AFL_ST_N          3
`define AFL_ST_BUSY       4
`define AFL_FLAGS_RESET   4'h0

// Opcode word: 0000 01F1 101R dddd
`define AFL_OP_MASK       16'hfde0
`define AFL_OP_MATCH      16'h05a0
`define AFL_OP_F_BIT      9
`define AFL_OP_R_BIT      4
`define AFL_OP_RD_LSB     0

// Source bit address split
`define AFL_BITOFS_W      4
`define AFL_WORD_BITS     16

// Cycle figures for an aligned source, zero-wait memory
`define AFL_STATES_BASE   4'h5
`define AFL_STATES_STEP   4'h2
`define AFL_CYC_MAX       4'hf

`endif

//--- afl_pkg.sv
// Types shared by the absolute field load unit.
package afl_pkg;

  typedef enum logic [2:0] {
    AFL_IDLE,
    AFL_ADDR_LO,
    AFL_ADDR_HI,
    AFL_READ,
    AFL_FINISH
  } afl_state_t;

  // Field width 1..32, held in six bits
  typedef logic [5:0] afl_width_t;

  // Three memory words cover any 32-bit field at any bit offset
  typedef logic [47:0] afl_window_t;

endpackage : afl_pkg

//--- afl_field_extract.sv
// Right-justifies a field from the fetched word window and extends it to 32 bits.
`timescale 1ns/1ps

module afl_field_extract (
  // Fetched window and field shape
  input  wire afl_pkg::afl_window_t window_in,
  input  wire logic [3:0]           bit_offset_in,
  input  wire afl_pkg::afl_width_t  width_in,
  input  wire logic                 sign_extend_in,
  // Extended result and compare against zero
  output logic [31:0]               value_out,
  output logic                      negative_out,
  output logic                      zero_out
);

  logic [47:0] shifted;
  logic [31:0] raw;
  logic [31:0] mask;
  logic        sign_bit;
  logic [4:0]  top_idx;

  always_comb begin
    shifted = window_in >> bit_offset_in;
    raw     = shifted[31:0];
    top_idx = 5'(width_in - 6'h01);
    // Width 32 cannot be built by a shift of a 32-bit one
    if (width_in[5]) begin
      mask = 32'hffff_ffff;
    end else begin
      mask = (32'h0000_0001 << width_in[4:0]) - 32'h0000_0001;
    end
    sign_bit = raw[top_idx];
    if (sign_extend_in && sign_bit) begin
      value_out = raw | ~mask;
    end else begin
      value_out = raw & mask;
    end
    negative_out = value_out[31];
    zero_out     = (value_out == 32'h0000_0000);
  end

endmodule : afl_field_extract

//--- afl_field_load.sv
// Executes the absolute-address field load into a general register.
`timescale 1ns/1ps
`include "afl_cfg.svh"

module afl_field_load (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Instruction word stream from the core
  input  wire logic [15:0] instr_word_in,
  input  wire logic        instr_valid_in,
  output logic             instr_ready_out,
  // Field-access path to local memory
  output logic             mem_rd_out,
  output logic [31:0]      mem_addr_out,
  input  wire logic [15:0] mem_data_in,
  input  wire logic        mem_ack_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [31:0]      reg_rdata_out,
  // Status
  output logic             flag_n_out,
  output logic             flag_c_out,
  output logic             flag_z_out,
  output logic             flag_v_out,
  output logic             busy_out,
  output logic             done_out,
  output logic             illegal_out
);

  afl_pkg::afl_state_t  state_q;
  afl_pkg::afl_window_t window_q;
  afl_pkg::afl_width_t  width_q;
  logic [31:0]          cfg_q;
  logic [31:0]          addr_q;
  logic [31:0]          rf_q [32];
  logic [3:0]           flags_q;
  logic [3:0]           cyc_q;
  logic [1:0]           rd_cnt_q;
  logic                 sel_q;
  logic                 file_q;
  logic [3:0]           rd_idx_q;
  logic                 ext_q;
  logic                 done_q;
  logic                 illegal_q;
  logic [31:0]          rdata_q;

  logic                 take;
  logic                 op_match;
  logic [1:0]           nwords;
  logic [3:0]           min_states;
  logic                 finish_now;
  logic [31:0]          ext_value;
  logic                 ext_neg;
  logic                 ext_zero;
  logic                 cfg_wr;
  logic                 st_wr;
  logic [31:0]          rf_word;

  // Encoded width 0 stands for 32 bits
  function automatic afl_pkg::afl_width_t cfg_width(input logic [4:0] code);
    cfg_width = (code == 5'h00) ? 6'h20 : {1'b0, code};
  endfunction : cfg_width

  // Memory words spanned by a field at a bit offset
  function automatic logic [1:0] words_needed(input logic [3:0] ofs,
                                              input afl_pkg::afl_width_t w);
    logic [6:0] last;
    last         = 7'({3'h0, ofs}) + 7'(w) - 7'h01;
    words_needed = 2'(last >> `AFL_BITOFS_W) + 2'h1;
  endfunction : words_needed

  // Register decode, shared by read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  assign take     = instr_valid_in && instr_ready_out;
  assign op_match = (instr_word_in & `AFL_OP_MASK) == `AFL_OP_MATCH;
  assign cfg_wr   = reg_wr_in && is_reg(reg_addr_in, `AFL_OFS_CFG);
  assign st_wr    = reg_wr_in && is_reg(reg_addr_in, `AFL_OFS_STATUS);

  assign nwords     = words_needed(addr_q[3:0], width_q);
  // Each extra word adds two states, so fields spanning more words run longer
  assign min_states = `AFL_STATES_BASE + (`AFL_STATES_STEP * 4'(nwords - 2'h1));
  assign finish_now = (state_q == afl_pkg::AFL_FINISH) &&
                      (cyc_q >= (min_states - 4'h1));

  // Handshake outputs are combinational from state
  always_comb begin
    instr_ready_out = (state_q == afl_pkg::AFL_IDLE) ||
                      (state_q == afl_pkg::AFL_ADDR_LO) ||
                      (state_q == afl_pkg::AFL_ADDR_HI);
    mem_rd_out      = (state_q == afl_pkg::AFL_READ);
    // Word-aligned fetch; the bit offset is applied after assembly
    mem_addr_out    = {addr_q[31:`AFL_BITOFS_W] + 28'(rd_cnt_q), 4'h0};
  end

  afl_field_extract u_extract (
    .window_in      (window_q),
    .bit_offset_in  (addr_q[3:0]),
    .width_in       (width_q),
    .sign_extend_in (ext_q),
    .value_out      (ext_value),
    .negative_out   (ext_neg),
    .zero_out       (ext_zero)
  );

  // Sequencer
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= afl_pkg::AFL_IDLE;
    end else begin
      case (state_q)
        afl_pkg::AFL_IDLE: begin
          if (take && op_match) begin
            state_q <= afl_pkg::AFL_ADDR_LO;
          end
        end
        afl_pkg::AFL_ADDR_LO: begin
          if (take) begin
            state_q <= afl_pkg::AFL_ADDR_HI;
          end
        end
        afl_pkg::AFL_ADDR_HI: begin
          if (take) begin
            state_q <= afl_pkg::AFL_READ;
          end
        end
        afl_pkg::AFL_READ: begin
          if (mem_ack_in && (rd_cnt_q == (nwords - 2'h1))) begin
            state_q <= afl_pkg::AFL_FINISH;
          end
        end
        afl_pkg::AFL_FINISH: begin
          if (finish_now) begin
            state_q <= afl_pkg::AFL_IDLE;
          end
        end
        default: begin
          state_q <= afl_pkg::AFL_IDLE;
        end
      endcase
    end
  end

  // Opcode fields
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sel_q    <= 1'b0;
      file_q   <= 1'b0;
      rd_idx_q <= 4'h0;
    end else if (take && (state_q == afl_pkg::AFL_IDLE) && op_match) begin
      sel_q    <= instr_word_in[`AFL_OP_F_BIT];
      file_q   <= instr_word_in[`AFL_OP_R_BIT];
      rd_idx_q <= instr_word_in[`AFL_OP_RD_LSB +: 4];
    end
  end

  // Source bit address, low half then high half
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_q <= 32'h0000_0000;
    end else if (take && (state_q == afl_pkg::AFL_ADDR_LO)) begin
      addr_q[15:0] <= instr_word_in;
    end else if (take && (state_q == afl_pkg::AFL_ADDR_HI)) begin
      addr_q[31:16] <= instr_word_in;
    end
  end

  // Field shape captured once, so a mid-operation setting change cannot tear it
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      width_q <= 6'h20;
      ext_q   <= 1'b0;
    end else if (take && (state_q == afl_pkg::AFL_ADDR_HI)) begin
      if (sel_q) begin
        width_q <= cfg_width(cfg_q[`AFL_CFG_W1_LSB +: 5]);
        ext_q   <= cfg_q[`AFL_CFG_E1_BIT];
      end else begin
        width_q <= cfg_width(cfg_q[`AFL_CFG_W0_LSB +: 5]);
        ext_q   <= cfg_q[`AFL_CFG_E0_BIT];
      end
    end
  end

  // Field configuration, written only by a register-port write to the configuration offset
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_q <= `AFL_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= reg_wdata_in;
    end
  end

  // Word gathering, lowest address into the lowest lane
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      window_q <= 48'h0000_0000_0000;
      rd_cnt_q <= 2'h0;
    end else if (take && (state_q == afl_pkg::AFL_ADDR_HI)) begin
      window_q <= 48'h0000_0000_0000;
      rd_cnt_q <= 2'h0;
    end else if (mem_rd_out && mem_ack_in) begin
      window_q[`AFL_WORD_BITS * rd_cnt_q +: `AFL_WORD_BITS] <= mem_data_in;
      rd_cnt_q <= rd_cnt_q + 2'h1;
    end
  end

  // State count from the opcode word, saturating
  // The opcode cycle is the first state, so the count starts at one
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cyc_q <= 4'h0;
    end else if (take && (state_q == afl_pkg::AFL_IDLE)) begin
      cyc_q <= 4'h1;
    end else if ((state_q != afl_pkg::AFL_IDLE) && (cyc_q != `AFL_CYC_MAX)) begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  // General registers: file in the top index bit
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 32'h0000_0000;
      end
    end else if (finish_now) begin
      rf_q[{file_q, rd_idx_q}] <= ext_value;
    end
  end

  // Flags: the load wins over a same-cycle software write
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_q <= `AFL_FLAGS_RESET;
    end else if (finish_now) begin
      flags_q[`AFL_ST_N] <= ext_neg;
      flags_q[`AFL_ST_Z] <= ext_zero;
      flags_q[`AFL_ST_V] <= 1'b0;
    end else if (st_wr) begin
      flags_q <= reg_wdata_in[3:0];
    end
  end

  // Pulses
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      done_q    <= finish_now;
      illegal_q <= take && (state_q == afl_pkg::AFL_IDLE) && !op_match;
    end
  end

  // Register read data, one cycle after the strobe
  always_comb begin
    rf_word = rf_q[reg_addr_in[6:2]];
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      if (is_reg(reg_addr_in, `AFL_OFS_CFG)) begin
        rdata_q <= cfg_q;
      end else if (is_reg(reg_addr_in, `AFL_OFS_STATUS)) begin
        rdata_q <= {27'h0, (state_q != afl_pkg::AFL_IDLE), flags_q};
      end else if (((reg_addr_in & `AFL_OFS_RF_MASK) == `AFL_OFS_RF_BASE) &&
                   (reg_addr_in[1:0] == 2'h0)) begin
        rdata_q <= rf_word;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign flag_n_out    = flags_q[`AFL_ST_N];
  assign flag_c_out    = flags_q[`AFL_ST_C];
  assign flag_z_out    = flags_q[`AFL_ST_Z];
  assign flag_v_out    = flags_q[`AFL_ST_V];
  assign busy_out      = (state_q != afl_pkg::AFL_IDLE);
  assign done_out      = done_q;
  assign illegal_out   = illegal_q;

endmodule : afl_field_load

//--- afl_load_monitor.sv
// Port-level property checker for the absolute field load unit.
`timescale 1ns/1ps
`include "afl_cfg.svh"

module afl_load_monitor (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  // Instruction stream
  input wire logic [15:0] instr_word_in,
  input wire logic        instr_valid_in,
  input wire logic        instr_ready_out,
  // Memory path
  input wire logic        mem_rd_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic        mem_ack_in,
  // Register port and status
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        flag_n_out,
  input wire logic        flag_z_out,
  input wire logic        flag_v_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire logic        illegal_out
);
  logic take_op;
  logic op_ok;

  assign take_op = instr_valid_in && instr_ready_out && !busy_out;
  assign op_ok   = (instr_word_in & `AFL_OP_MASK) == `AFL_OP_MATCH;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_done_single : assert property (done_out |=> !done_out)
    else $error("done pulse longer than one cycle");
  a_illegal_single : assert property (illegal_out |=> !illegal_out)
    else $error("illegal pulse longer than one cycle");
  a_opcode_starts : assert property (take_op && op_ok |=> busy_out && !illegal_out)
    else $error("matching opcode did not start an operation");
  a_opcode_drop : assert property (take_op && !op_ok |=> illegal_out && !busy_out)
    else $error("bad opcode not dropped");
  a_min_states : assert property ($rose(busy_out) |-> !done_out [*4])
    else $error("operation finished too early");
  a_read_holds : assert property (mem_rd_out && !mem_ack_in |=> mem_rd_out && $stable(mem_addr_out))
    else $error("memory request dropped or moved before ack");
  a_word_aligned : assert property (mem_rd_out |-> mem_addr_out[3:0] == 4'h0 && !instr_ready_out)
    else $error("memory request not word aligned");
  a_done_flags : assert property (done_out |-> !flag_v_out && !(flag_z_out && flag_n_out) && !busy_out)
    else $error("flags inconsistent at completion");
  a_rdata_quiet : assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");

  c_done : cover property (done_out);
  c_illegal : cover property (illegal_out);
  c_mem_wait : cover property (mem_rd_out && !mem_ack_in);
  c_negative : cover property (done_out && flag_n_out);
endmodule : afl_load_monitor

bind afl_field_load afl_load_monitor afl_load_monitor_i (
  .sys_clk_in, .reset_n_in, .instr_word_in, .instr_valid_in, .instr_ready_out,
  .mem_rd_out, .mem_addr_out, .mem_ack_in, .reg_rd_in, .reg_rdata_out,
  .flag_n_out, .flag_z_out, .flag_v_out, .busy_out, .done_out, .illegal_out
);

//--- afl_mem_model.sv
// Local memory model answering word reads of the field-access path.
`timescale 1ns/1ps

module afl_mem_model (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_n_in,
  // Read request and answer
  input  wire logic        mem_rd_in,
  input  wire logic [31:0] mem_addr_in,
  input  wire logic        slow_in,
  output logic [15:0]      mem_data_out,
  output logic             mem_ack_out
);
  logic [1:0]  wait_q;
  logic [15:0] last_q;

  // Content is a fixed scramble of the word index
  function automatic logic [15:0] word_at(logic [31:0] a);
    return (a[19:4] * 16'h9e37) ^ 16'h5a5a;
  endfunction : word_at

  // Slow mode answers on the third request cycle
  assign mem_ack_out  = mem_rd_in && (!slow_in || wait_q == 2'h2);
  // Unanswered data never repeats the last word
  assign mem_data_out = mem_ack_out ? word_at(mem_addr_in) : ~last_q;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wait_q <= 2'h0;
      last_q <= 16'h0;
    end else begin
      wait_q <= (mem_rd_in && !mem_ack_out) ? wait_q + 2'h1 : 2'h0;
      if (mem_ack_out) begin
        last_q <= mem_data_out;
      end
    end
  end
endmodule : afl_mem_model

//--- tb.sv
// Self-checking bench for the absolute field load unit.
`timescale 1ns/1ps
`include "afl_cfg.svh"

module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] iw = 16'h0;
  logic        iv = 1'b0;
  logic [7:0]  ra = 8'h0;
  logic [31:0] rwd = 32'h0;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic        slow = 1'b0;
  logic        rd_q = 1'b0;
  logic        rdy, mrd, mack, done, ill, busy, fn, fc, fz, fv;
  logic [31:0] maddr, rdat, r;
  logic [15:0] mdat;
  logic [31:0] lfsr = 32'hbab2;
  logic [31:0] expq[$];
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #2 clk = ~clk;

  afl_field_load afl_field_load_i (
    .sys_clk_in(clk), .reset_n_in(rst_n), .instr_word_in(iw), .instr_valid_in(iv),
    .instr_ready_out(rdy), .mem_rd_out(mrd), .mem_addr_out(maddr), .mem_data_in(mdat),
    .mem_ack_in(mack), .reg_addr_in(ra), .reg_wdata_in(rwd), .reg_wr_in(rwr),
    .reg_rd_in(rrd), .reg_rdata_out(rdat), .flag_n_out(fn), .flag_c_out(fc),
    .flag_z_out(fz), .flag_v_out(fv), .busy_out(busy), .done_out(done), .illegal_out(ill)
  );

  afl_mem_model afl_mem_model_i (
    .sys_clk_in(clk), .reset_n_in(rst_n), .mem_rd_in(mrd), .mem_addr_in(maddr),
    .slow_in(slow), .mem_data_out(mdat), .mem_ack_out(mack)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Expected field: bits gathered upward from the bit address
  function automatic logic [31:0] field(logic [31:0] a, int w, logic sx);
    logic [31:0] v;
    logic [31:0] b;
    logic [15:0] m;
    v = 32'h0;
    for (int i = 0; i < w; i++) begin
      b = a + i;
      m = afl_mem_model_i.word_at({b[31:4], 4'h0});
      v[i] = m[b[3:0]];
    end
    if (sx && v[w-1])
      v = v | (32'hffffffff << w);
    return v;
  endfunction : field

  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Idle cycle after each strobe keeps one assignment per time step
  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    ra <= a;
    rwd <= d;
    rwr <= 1'b1;
    @(posedge clk);
    rwr <= 1'b0;
    @(posedge clk);
  endtask : reg_wr

  task automatic reg_chk(logic [7:0] a, logic [31:0] e);
    expq.push_back(e);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk);
    rrd <= 1'b0;
    @(posedge clk);
  endtask : reg_chk

  task automatic send(logic [15:0] w);
    logic ok;
    iw <= w;
    iv <= 1'b1;
    do begin
      @(negedge clk);
      ok = rdy;
      @(posedge clk);
    end while (!ok);
  endtask : send

  task automatic run_op(logic f, logic rf, logic [3:0] d, logic [31:0] a, logic [31:0] cfg,
                        logic [3:0] fl, int n);
    logic [4:0]  wc;
    logic [31:0] e;
    int          t0;
    wc = f ? cfg[12:8] : cfg[4:0];
    e = field(a, (wc == 5'h0) ? 32 : int'(wc), f ? cfg[13] : cfg[5]);
    reg_wr(`AFL_OFS_CFG, cfg);
    reg_wr(`AFL_OFS_STATUS, {28'h0, fl});
    send(`AFL_OP_MATCH | {6'h0, f, 4'h0, rf, d});
    t0 = cyc;
    send(a[15:0]);
    send(a[31:16]);
    iv <= 1'b0;
    while (!done && cyc - t0 < 100)
      @(negedge clk);
    chk("done_out", 32'h1, {31'h0, done});
    chk("busy_out", 32'h0, {31'h0, busy});
    chk("flag pins", {28'h0, e[31], fl[2], e == 32'h0, 1'b0}, {28'h0, fn, fc, fz, fv});
    if (n > 0)
      chk("done cycles", n, cyc - t0);
    @(posedge clk);
    reg_chk(`AFL_OFS_RF_BASE + {1'b0, rf, d, 2'b00}, e);
    reg_chk(`AFL_OFS_STATUS, {28'h0, e[31], fl[2], e == 32'h0, 1'b0});
    reg_chk(`AFL_OFS_CFG, cfg);
  endtask : run_op

  always @(posedge clk) begin
    rd_q <= rrd;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end

  always @(negedge clk) begin
    if (rd_q)
      chk("reg_rdata_out", expq.pop_front(), rdat);
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reg_chk(`AFL_OFS_CFG, 32'h0);
    reg_chk(`AFL_OFS_STATUS, 32'h0);
    reg_wr(8'h84, 32'h1234);
    reg_chk(8'h84, 32'h0);
    reg_chk(8'h40, 32'h0);
    run_op(1'b0, 1'b0, 4'h3, 32'h15500, 32'h0010, 4'hf, 5);
    run_op(1'b1, 1'b1, 4'h5, 32'h15510, 32'h0000, 4'h4, 7);
    run_op(1'b1, 1'b0, 4'h0, 32'h1550d, 32'h2c00, 4'h0, 0);
    run_op(1'b0, 1'b1, 4'hf, 32'h15501, 32'h0001, 4'h1, 0);
    send(16'hffff);
    iv <= 1'b0;
    @(negedge clk);
    chk("illegal_out", 32'h1, {31'h0, ill});
    // Back to the rising edge before the next driver starts
    @(posedge clk);
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      slow <= r[0];
      run_op(r[1], r[2], r[6:3], rnd(), rnd() & 32'h3f3f, r[10:7], 0);
    end
    repeat (4) @(posedge clk);
    tally_and_finish();
  end
endmodule : tb
